//--- rtl/osc_wait_counter.sv
/*
 One oscillation stabilization wait counter, advanced by oscillator ticks.
 Assumes tick is a one-cycle pulse per oscillator cycle, synchronous to clock.
*/
`timescale 1ns/1ps
`default_nettype none
module osc_wait_counter (
   input wire logic clock,
   input wire logic sys_rst,
   osc_wait_if.counter waitPort
);
   import pll_osc_pkg::*;
   typedef struct packed {
      logic [pll_osc_pkg::CNT_W-1:0] count;
      logic ready;
   } cnt_state_t;
   cnt_state_t state_reg;
   cnt_state_t state_next;

   assign waitPort.ready = state_reg.ready;

   always_comb begin
      state_next = state_reg;
      if (!waitPort.run) begin
         // Stopped oscillator restarts its wait from zero
         state_next = '0;
      end else begin
         // RULE19 count oscillator cycles
         if (waitPort.tick && state_reg.count < waitPort.target) begin
            state_next.count = state_reg.count + 16'h0001;
         end
         // RULE13 at least target, one extra allowed
         state_next.ready = (state_reg.count >= waitPort.target);
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end
endmodule : osc_wait_counter
`default_nettype wire

//--- rtl/osc_wait_if.sv
/*
 Bundle between the controller and one stabilization wait counter.
 Assumes the counter and controller share one clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface osc_wait_if;
   import pll_osc_pkg::*;
   logic run;
   logic tick;
   logic [CNT_W-1:0] target;
   logic ready;
   modport ctrl (output run, output tick, output target, input ready);
   modport counter (input run, input tick, input target, output ready);
endinterface : osc_wait_if
`default_nettype wire

//--- rtl/pll_and_osc_wait_control.sv
/*
 PLL enable/multiplier control, PLL ready, and oscillator wait settings
 with three wait counters, a byte register port and an interrupt.
 Assumes oscillator ticks and mode monitor are synchronous to clock;
 the mode sequencer drives the monitor and the oscillator enables.
*/
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Operation
// RULE1: Selecting PLL mode sets the PLL enable bit automatically.
// RULE2: Writing zero to PLL enable is ignored while select or monitor shows PLL.
// RULE3: Changing to any non-PLL mode clears the PLL enable bit.
// RULE4: Writing one to PLL enable is ignored in subclock or sub-CR mode.
// RULE5: PLL enable is bit 7; one enables, zero disables the PLL.
// RULE6: Multiplier bits 6:5 select x2, x2.5, x3, x4.
// RULE7: Multiplier writes accepted only while the PLL clock is stopped.
// RULE8: Software must not write the multiplier while PLL mode is selected or active.
// RULE9: PLL ready at bit 4 reads one only after the PLL wait elapsed.
// RULE10: Bits 3:0 of PLL control read zero and ignore writes.
// RULE11: Subclock wait is 2^code-2 cycles, codes below 2 give none.
// RULE12: Main wait is 2^(code-1)-2 cycles, codes below 3 give none.
// RULE13: Programmed count is minimum; wait may run one cycle longer.
// RULE14: Software must not change subclock wait field during the subclock wait.
// RULE15: Software must not change main wait field during the main wait.
// RULE16: Mode codes 000 sub, 010 main, 100 sub-CR, 110 main CR, 111 PLL.
// RULE17: PLL wait runs only after the main CR wait has completed.
// RULE18: After power-on reset waits use initial values, not register settings.
// RULE19: Each wait has its own counter; ready rises when count is reached.
module pll_and_osc_wait_control (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic powerOnReset,
   input wire logic [pll_osc_pkg::ADDR_W-1:0] regAddr,
   input wire logic [pll_osc_pkg::DATA_W-1:0] regWriteData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [pll_osc_pkg::DATA_W-1:0] regReadData,
   input wire logic [2:0] clock_mode_monitor,
   input wire logic sub_osc_enable_bit,
   input wire logic main_osc_enable_bit,
   input wire logic mainCrReady,
   input wire logic subOscTick,
   input wire logic mainOscTick,
   input wire logic pllOscTick,
   output logic [2:0] clock_mode_select,
   output logic pll_enable_bit,
   output logic [1:0] pll_multiplier_select,
   output logic pll_ready_flag,
   output logic sub_osc_ready_flag,
   output logic main_osc_ready_flag,
   output logic irq
);
   import pll_osc_pkg::*;

   typedef struct packed {
      logic pllEn;
      logic [1:0] pllMult;
      logic [7:0] waitSetting;
      logic [2:0] modeSel;
      logic [2:0] monPrev;
      logic porWaits;
      logic [pll_osc_pkg::EVT_W-1:0] readyPrev;
      logic [pll_osc_pkg::EVT_W-1:0] status;
      logic [pll_osc_pkg::EVT_W-1:0] mask;
      logic [pll_osc_pkg::DATA_W-1:0] rdata;
      logic irq;
      logic [2:0] modeSelOut;
      logic pllEnOut;
      logic [1:0] pllMultOut;
      logic [pll_osc_pkg::EVT_W-1:0] readyOut;
   } ctrl_state_t;
   ctrl_state_t state_reg;
   ctrl_state_t state_next;

   osc_wait_if subWait();
   osc_wait_if mainWait();
   osc_wait_if pllWait();

   // Wait length for a code, offset says how far the exponent lags the code
   function automatic logic [CNT_W-1:0] wait_cycles(input logic [3:0] code, input logic [3:0] minCode,
                                                    input logic [3:0] expLag);
      logic [CNT_W-1:0] one;
      one = 16'h0001;
      if (code < minCode) begin
         wait_cycles = '0;
      end else begin
         wait_cycles = (one << (code - expLag)) - WAIT_SUBTRAHEND;
      end
   endfunction : wait_cycles

   function automatic logic is_pll_mode(input logic [2:0] mode);
      is_pll_mode = (mode == MODE_MAIN_CR_PLL);
   endfunction : is_pll_mode

   logic [3:0] subCode;
   logic [3:0] mainCode;
   logic [EVT_W-1:0] readyNow;

   // RULE18 initial waits after power-on
   assign subCode = state_reg.porWaits ? SUB_WAIT_POR_CODE : state_reg.waitSetting[SUB_WAIT_HI:SUB_WAIT_LO];
   assign mainCode = state_reg.porWaits ? MAIN_WAIT_POR_CODE : state_reg.waitSetting[MAIN_WAIT_HI:MAIN_WAIT_LO];

   // RULE11 subclock wait length
   assign subWait.target = wait_cycles(subCode, SUB_WAIT_MIN_CODE, 4'h0);
   // RULE12 main wait length
   assign mainWait.target = wait_cycles(mainCode, MAIN_WAIT_MIN_CODE, 4'h1);
   assign pllWait.target = PLL_WAIT_CYCLES;
   assign subWait.run = sub_osc_enable_bit;
   assign mainWait.run = main_osc_enable_bit;
   // RULE17 PLL wait follows main CR wait
   assign pllWait.run = state_reg.pllEn & mainCrReady;
   assign subWait.tick = subOscTick;
   assign mainWait.tick = mainOscTick;
   assign pllWait.tick = pllOscTick;

   // RULE19 dedicated counters
   osc_wait_counter subCounter (.clock(clock), .sys_rst(sys_rst), .waitPort(subWait.counter));
   osc_wait_counter mainCounter (.clock(clock), .sys_rst(sys_rst), .waitPort(mainWait.counter));
   osc_wait_counter pllCounter (.clock(clock), .sys_rst(sys_rst), .waitPort(pllWait.counter));

   assign readyNow[EVT_SUB] = subWait.ready;
   assign readyNow[EVT_MAIN] = mainWait.ready;
   assign readyNow[EVT_PLL] = pllWait.ready;

   assign regReadData = state_reg.rdata;
   assign irq = state_reg.irq;
   assign clock_mode_select = state_reg.modeSelOut;
   assign pll_enable_bit = state_reg.pllEnOut;
   assign pll_multiplier_select = state_reg.pllMultOut;
   assign sub_osc_ready_flag = state_reg.readyOut[EVT_SUB];
   assign main_osc_ready_flag = state_reg.readyOut[EVT_MAIN];
   assign pll_ready_flag = state_reg.readyOut[EVT_PLL];

   always_comb begin
      logic [EVT_W-1:0] rises;
      logic [EVT_W-1:0] clearBits;
      logic wrPll;
      logic monIsPll;
      rises = '0;
      clearBits = '0;
      wrPll = regWrite && regAddr == PLL_CONTROL_ADDR;
      monIsPll = is_pll_mode(clock_mode_monitor);
      state_next = state_reg;
      state_next.monPrev = clock_mode_monitor;
      state_next.readyPrev = readyNow;
      rises = readyNow & ~state_reg.readyPrev;

      if (wrPll) begin
         // RULE5 enable bit write
         if (regWriteData[PLL_EN_BIT]) begin
            // RULE4 no enable in sub modes
            if (clock_mode_monitor != MODE_SUB && clock_mode_monitor != MODE_SUB_CR) begin
               state_next.pllEn = 1'b1;
            end
         // RULE2 clear blocked in PLL mode
         end else if (!is_pll_mode(state_reg.modeSel) && !monIsPll) begin
            state_next.pllEn = 1'b0;
         end
         // RULE7 multiplier only while PLL stopped
         if (!monIsPll && !state_reg.pllEn) begin
            // RULE6 multiplier code stored as written
            state_next.pllMult = regWriteData[PLL_MULT_HI:PLL_MULT_LO];
         end
      end
      // RULE3 leaving to a non-PLL mode
      if (clock_mode_monitor != state_reg.monPrev && !monIsPll) begin
         state_next.pllEn = 1'b0;
      end
      if (regWrite && regAddr == OSC_WAIT_SETTING_ADDR) begin
         state_next.waitSetting = regWriteData;
      end
      if (regWrite && regAddr == CLOCK_MODE_ADDR) begin
         // RULE16 mode select code
         state_next.modeSel = regWriteData[MODE_SEL_HI:MODE_SEL_LO];
         // RULE1 PLL mode sets enable
         if (is_pll_mode(regWriteData[MODE_SEL_HI:MODE_SEL_LO])) begin
            state_next.pllEn = 1'b1;
         end
      end
      if (regWrite && regAddr == IRQ_MASK_ADDR) begin
         state_next.mask = regWriteData[EVT_W-1:0];
      end
      if (regWrite && regAddr == IRQ_STATUS_ADDR) begin
         clearBits = regWriteData[EVT_W-1:0];
      end
      // New ready edge wins over a same-cycle clear
      state_next.status = (state_reg.status & ~clearBits) | rises;
      state_next.irq = |(state_next.status & state_next.mask);

      state_next.rdata = '0;
      if (regRead) begin
         case (regAddr)
            PLL_CONTROL_ADDR: begin
               // RULE9 ready flag, RULE10 low nibble zero
               state_next.rdata[PLL_EN_BIT] = state_reg.pllEn;
               state_next.rdata[PLL_MULT_HI:PLL_MULT_LO] = state_reg.pllMult;
               state_next.rdata[PLL_RDY_BIT] = readyNow[EVT_PLL];
            end
            OSC_WAIT_SETTING_ADDR: state_next.rdata = state_reg.waitSetting;
            CLOCK_MODE_ADDR: begin
               state_next.rdata[MODE_MON_HI:MODE_MON_LO] = clock_mode_monitor;
               state_next.rdata[MODE_SEL_HI:MODE_SEL_LO] = state_reg.modeSel;
            end
            IRQ_STATUS_ADDR: state_next.rdata[EVT_W-1:0] = state_reg.status;
            IRQ_MASK_ADDR: state_next.rdata[EVT_W-1:0] = state_reg.mask;
            default: state_next.rdata = '0;
         endcase
      end
      state_next.modeSelOut = state_next.modeSel;
      state_next.pllEnOut = state_next.pllEn;
      state_next.pllMultOut = state_next.pllMult;
      state_next.readyOut = readyNow;
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_reg <= '0;
         state_reg.pllMult <= PLL_MULT_RESET;
         state_reg.pllMultOut <= PLL_MULT_RESET;
         state_reg.waitSetting <= OSC_WAIT_RESET;
         state_reg.modeSel <= MODE_SEL_RESET;
         state_reg.modeSelOut <= MODE_SEL_RESET;
         state_reg.monPrev <= MODE_SEL_RESET;
         // RULE18 synchronous capture of reset source
         state_reg.porWaits <= powerOnReset;
      end else begin
         state_reg <= state_next;
      end
   end
endmodule : pll_and_osc_wait_control
`default_nettype wire

//--- rtl/pll_osc_pkg.sv
/*
 Shared constants for the PLL and oscillator wait control block.
 Assumes an 8-bit register port and oscillator ticks synchronous to clock.
*/
package pll_osc_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 3;
   localparam int CNT_W = 16;
   localparam logic [ADDR_W-1:0] PLL_CONTROL_ADDR = 3'h0;
   localparam logic [ADDR_W-1:0] OSC_WAIT_SETTING_ADDR = 3'h1;
   localparam logic [ADDR_W-1:0] CLOCK_MODE_ADDR = 3'h2;
   localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = 3'h3;
   localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 3'h4;
   // pll_control fields
   localparam int PLL_EN_BIT = 7;
   localparam int PLL_MULT_HI = 6;
   localparam int PLL_MULT_LO = 5;
   localparam int PLL_RDY_BIT = 4;
   localparam logic [1:0] PLL_MULT_RESET = 2'h0;
   // osc_wait_setting fields
   localparam int SUB_WAIT_HI = 7;
   localparam int SUB_WAIT_LO = 4;
   localparam int MAIN_WAIT_HI = 3;
   localparam int MAIN_WAIT_LO = 0;
   localparam logic [7:0] OSC_WAIT_RESET = 8'hff;
   localparam logic [3:0] SUB_WAIT_POR_CODE = 4'hf;
   localparam logic [3:0] MAIN_WAIT_POR_CODE = 4'hf;
   localparam logic [3:0] SUB_WAIT_MIN_CODE = 4'h2;
   localparam logic [3:0] MAIN_WAIT_MIN_CODE = 4'h3;
   localparam logic [CNT_W-1:0] WAIT_SUBTRAHEND = 16'h0002;
   localparam logic [CNT_W-1:0] PLL_WAIT_CYCLES = 16'h1000;
   // clock mode register fields
   localparam int MODE_MON_HI = 7;
   localparam int MODE_MON_LO = 5;
   localparam int MODE_SEL_HI = 4;
   localparam int MODE_SEL_LO = 2;
   typedef enum logic [2:0] {
      MODE_SUB = 3'h0,
      MODE_MAIN = 3'h2,
      MODE_SUB_CR = 3'h4,
      MODE_MAIN_CR = 3'h6,
      MODE_MAIN_CR_PLL = 3'h7
   } clock_mode_t;
   localparam logic [2:0] MODE_SEL_RESET = 3'h6;
   localparam int EVT_SUB = 0;
   localparam int EVT_MAIN = 1;
   localparam int EVT_PLL = 2;
   localparam int EVT_W = 3;
endpackage : pll_osc_pkg

//--- sim/pll_and_osc_wait_control_sva.sv
/*
 Port-level checker for the PLL and oscillator wait control block.
 Assumes binding to the top module; sees its ports only.
*/
`timescale 1ns/1ps
`default_nettype none
module pll_and_osc_wait_control_sva (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [pll_osc_pkg::ADDR_W-1:0] regAddr,
   input wire logic [pll_osc_pkg::DATA_W-1:0] regWriteData,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [pll_osc_pkg::DATA_W-1:0] regReadData,
   input wire logic [2:0] clock_mode_monitor,
   input wire logic mainCrReady,
   input wire logic pllOscTick,
   input wire logic [2:0] clock_mode_select,
   input wire logic pll_enable_bit,
   input wire logic [1:0] pll_multiplier_select,
   input wire logic pll_ready_flag
);
   import pll_osc_pkg::*;
   logic [12:0] tickCnt_reg;
   logic wrCtl;
   logic wrMode;
   assign wrCtl = regWrite && regAddr == PLL_CONTROL_ADDR;
   assign wrMode = regWrite && regAddr == CLOCK_MODE_ADDR;
   // Saturates at the PLL wait length, enough for the minimum check
   always_ff @(posedge clock) begin
      if (sys_rst || !(pll_enable_bit && mainCrReady)) tickCnt_reg <= 13'h0000;
      else if (pllOscTick && !tickCnt_reg[12]) tickCnt_reg <= tickCnt_reg + 13'h0001;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   chk_sel_sets_en: assert property (wrMode && regWriteData[4:2] == 3'h7 |=> pll_enable_bit && clock_mode_select == 3'h7)
      else $error("PLL select did not set enable");
   chk_zero_ignored: assert property (wrCtl && !regWriteData[7] && pll_enable_bit && $stable(clock_mode_monitor)
      && (clock_mode_monitor == 3'h7 || clock_mode_select == 3'h7) |=> pll_enable_bit) else $error("enable cleared in PLL mode");
   chk_mode_clears: assert property ($changed(clock_mode_monitor) && clock_mode_monitor != 3'h7 && !wrMode
      |=> ##[0:1] !pll_enable_bit) else $error("enable kept after mode change");
   chk_one_ignored: assert property (wrCtl && regWriteData[7] && !pll_enable_bit
      && (clock_mode_monitor == 3'h0 || clock_mode_monitor == 3'h4) |=> !pll_enable_bit) else $error("enable set in sub mode");
   chk_mult_locked: assert property (pll_enable_bit || clock_mode_monitor == 3'h7 |=> $stable(pll_multiplier_select))
      else $error("multiplier changed while PLL running");
   chk_pll_stopped: assert property (!pll_enable_bit [*4] |-> !pll_ready_flag)
      else $error("PLL ready while stopped");
   chk_pll_wait_min: assert property ($rose(pll_ready_flag) |-> tickCnt_reg[12])
      else $error("PLL ready before its wait");
   chk_rsvd_zero: assert property (regRead && regAddr == PLL_CONTROL_ADDR |=> regReadData[3:0] == 4'h0)
      else $error("reserved bits not zero");
endmodule : pll_and_osc_wait_control_sva
bind pll_and_osc_wait_control pll_and_osc_wait_control_sva i_pll_and_osc_wait_control_sva (.clock, .sys_rst, .regAddr,
   .regWriteData, .regWrite, .regRead, .regReadData, .clock_mode_monitor, .mainCrReady, .pllOscTick, .clock_mode_select,
   .pll_enable_bit, .pll_multiplier_select, .pll_ready_flag);
`default_nettype wire

//--- sim/pll_and_osc_wait_control_tb_top.sv
/*
 Register-level testbench for the PLL and oscillator wait control block.
 Assumes oscillator ticks every clock while a counter runs.
*/
`timescale 1ns/1ps
`default_nettype none
module pll_and_osc_wait_control_tb_top;
   import pll_osc_pkg::*;
   logic clock, sys_rst, powerOnReset, regWrite, regRead, mainCrReady, pll_enable_bit, irq;
   logic sub_osc_enable_bit, main_osc_enable_bit, subOscTick, mainOscTick, pllOscTick;
   logic pll_ready_flag, sub_osc_ready_flag, main_osc_ready_flag;
   logic [2:0] regAddr, clock_mode_monitor, clock_mode_select;
   logic [7:0] regWriteData, regReadData;
   logic [1:0] pll_multiplier_select;
   int errCount, samplesChecked, cycles, n, tgt;
   pll_and_osc_wait_control i_pll_and_osc_wait_control (.clock, .sys_rst, .powerOnReset, .regAddr, .regWriteData,
      .regWrite, .regRead, .regReadData, .clock_mode_monitor, .sub_osc_enable_bit, .main_osc_enable_bit, .mainCrReady,
      .subOscTick, .mainOscTick, .pllOscTick, .clock_mode_select, .pll_enable_bit, .pll_multiplier_select,
      .pll_ready_flag, .sub_osc_ready_flag, .main_osc_ready_flag, .irq);
   always #20 clock = ~clock;
   task end_of_test;
      $display("comparisons %0d mismatches %0d", samplesChecked, errCount);
      if (errCount == 0 && samplesChecked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test
   // Hang guard, far above the expected few thousand cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 30000) begin
         errCount++;
         end_of_test();
      end
   end
   task chk(input logic [7:0] exp, input logic [7:0] got, input string nm);
      samplesChecked++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
         errCount++;
      end
   endtask : chk
   task wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clock);
      regAddr <= a;
      regWriteData <= d;
      regWrite <= 1'b1;
      @(posedge clock);
      regWrite <= 1'b0;
      // One more edge passes so outputs updated at the write edge are settled when read
      @(posedge clock);
   endtask : wr
   task rd(input logic [2:0] a, input logic [7:0] exp, input string nm);
      @(posedge clock);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clock);
      regRead <= 1'b0;
      @(posedge clock);
      chk(exp, regReadData, nm);
   endtask : rd
   task waitFlag(input logic isSub, input int code);
      tgt = isSub ? (code >= 2 ? (1 << code) - 2 : 0) : (code >= 3 ? (1 << (code - 1)) - 2 : 0);
      wr(3'h1, {code[3:0], code[3:0]}); // set while both oscillators stopped
      if (isSub) sub_osc_enable_bit <= 1'b1;
      else main_osc_enable_bit <= 1'b1;
      n = 0;
      while ((isSub ? sub_osc_ready_flag : main_osc_ready_flag) !== 1'b1 && n < 1000) begin
         @(posedge clock);
         n++;
      end
      samplesChecked++;
      if (n < tgt || n > tgt + 4) begin
         $display("MISMATCH waitCycles expected %0d seen %0d", tgt, n);
         errCount++;
      end
      sub_osc_enable_bit <= 1'b0;
      main_osc_enable_bit <= 1'b0;
      repeat (3) @(posedge clock);
   endtask : waitFlag
   initial begin
      clock = 1'b0;
      sys_rst = 1'b1;
      powerOnReset = 1'b0;
      regAddr = 3'h0;
      regWriteData = 8'h00;
      regWrite = 1'b0;
      regRead = 1'b0;
      clock_mode_monitor = 3'h6;
      sub_osc_enable_bit = 1'b0;
      main_osc_enable_bit = 1'b0;
      mainCrReady = 1'b0;
      subOscTick = 1'b1;
      mainOscTick = 1'b1;
      pllOscTick = 1'b1;
      repeat (4) @(posedge clock);
      sys_rst <= 1'b0;
      rd(PLL_CONTROL_ADDR, 8'h00, "pllControl");
      rd(OSC_WAIT_SETTING_ADDR, 8'hff, "oscWaitSetting");
      rd(CLOCK_MODE_ADDR, 8'hd8, "clockMode");
      rd(3'h7, 8'h00, "unmapped");
      for (int i = 0; i < 4; i++) begin
         wr(PLL_CONTROL_ADDR, {1'b0, i[1:0], 5'h1f});
         chk({6'h00, i[1:0]}, {6'h00, pll_multiplier_select}, "multiplier");
         rd(PLL_CONTROL_ADDR, {1'b0, i[1:0], 5'h00}, "pllControlMult");
      end
      for (int m = 0; m < 8; m += 4) begin
         clock_mode_monitor <= m[2:0];
         wr(PLL_CONTROL_ADDR, 8'he0);
         chk(8'h00, {7'h00, pll_enable_bit}, "enableSubMode");
      end
      clock_mode_monitor <= 3'h2;
      wr(PLL_CONTROL_ADDR, 8'he0);
      chk(8'h01, {7'h00, pll_enable_bit}, "enableOne");
      // Enabled PLL counts as running, so a new multiplier is refused
      wr(PLL_CONTROL_ADDR, 8'h80);
      chk(8'h03, {6'h00, pll_multiplier_select}, "multLocked");
      wr(PLL_CONTROL_ADDR, 8'h60);
      chk(8'h00, {7'h00, pll_enable_bit}, "enableZero");
      clock_mode_monitor <= 3'h6;
      wr(CLOCK_MODE_ADDR, 8'h1c);
      chk(8'h0f, {4'h0, clock_mode_select, pll_enable_bit}, "selectPll");
      wr(PLL_CONTROL_ADDR, 8'h60); // multiplier rewritten unchanged
      chk(8'h01, {7'h00, pll_enable_bit}, "enableZeroIgnored");
      repeat (100) @(posedge clock);
      chk(8'h00, {7'h00, pll_ready_flag}, "pllReadyNoMainCr");
      mainCrReady <= 1'b1;
      n = 0;
      while (pll_ready_flag !== 1'b1 && n < 5000) begin
         @(posedge clock);
         n++;
      end
      samplesChecked++;
      if (n < 4096 || n > 4100) begin
         $display("MISMATCH pllWait expected 4096 seen %0d", n);
         errCount++;
      end
      rd(PLL_CONTROL_ADDR, 8'hf0, "pllControlReady");
      rd(IRQ_STATUS_ADDR, 8'h04, "irqStatus");
      chk(8'h00, {7'h00, irq}, "irqMasked");
      wr(IRQ_MASK_ADDR, 8'h07);
      repeat (2) @(posedge clock);
      chk(8'h01, {7'h00, irq}, "irqRaised");
      wr(IRQ_STATUS_ADDR, 8'h04);
      repeat (2) @(posedge clock);
      chk(8'h00, {7'h00, irq}, "irqCleared");
      clock_mode_monitor <= 3'h7;
      repeat (3) @(posedge clock);
      clock_mode_monitor <= 3'h2;
      repeat (6) @(posedge clock);
      chk(8'h00, {6'h00, pll_enable_bit, pll_ready_flag}, "modeLeftPll");
      mainCrReady <= 1'b0;
      for (int c = 0; c < 7; c++) begin
         waitFlag(1'b1, c);
         waitFlag(1'b0, c);
      end
      rd(IRQ_STATUS_ADDR, 8'h03, "oscEvents");
      sys_rst <= 1'b1;
      powerOnReset <= 1'b1;
      repeat (4) @(posedge clock);
      sys_rst <= 1'b0;
      wr(OSC_WAIT_SETTING_ADDR, 8'h00);
      main_osc_enable_bit <= 1'b1;
      repeat (300) @(posedge clock);
      chk(8'h00, {7'h00, main_osc_ready_flag}, "porMainWait");
      end_of_test();
   end
endmodule : pll_and_osc_wait_control_tb_top
`default_nettype wire
